// ===== rtcac_alarm_ctrl.sv
// alarm matching, hold handshake and shared interrupt of the calendar counter
`default_nettype none
// Functional notes
// - weekday mask: seven day bits, bit7 zero
// - alarm only on days whose bit is set
// - 12h midnight 12, noon 32; 24h 00, 12
// - counter readable in any order while held
// - counter writable in any order while held
// - alarm registers writable in any order
// - shared interrupt, periodic and alarm flags
// - 12h hour bit5 marks afternoon
// - out-of-range alarm values never match
module rtcac_alarm_ctrl (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic fsub_pin,
	input wire rtcac_pkg::rtcac_sfr_req_t sfr_req,
	input wire rtcac_pkg::rtcac_time_t cur_time,
	input wire logic periodic_tick,
	output logic [7:0] sfr_rdata,
	output logic rtc_interrupt_request,
	output logic counter_run_enable,
	output logic hour_format_select,
	output logic counter_freeze
);
	logic [1:0] rst_pipe;
	logic rst_sync_n;
	logic fsub_tick;
	logic min_ok;
	logic hour_ok;
	logic match_now;
	rtcac_pkg::rtcac_state_t s;
	rtcac_pkg::rtcac_state_t next_s;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rst_pipe <= 2'h0;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end
	assign rst_sync_n = rst_pipe[1];

	rtcac_edge_sync u_fsub_sync (
		.sys_clk(sys_clk),
		.rst_sync_n(rst_sync_n),
		.async_in(fsub_pin),
		.rise(fsub_tick)
	);

	always_comb
	begin
		min_ok = (s.alarm_minute_value[3:0] <= 4'h9) && (s.alarm_minute_value <= rtcac_pkg::MIN_MAX);
	end

	// hour range per format, 12h uses afternoon marker
	always_comb
	begin
		hour_ok = 1'b0;
		if (s.alarm_hour_value[3:0] <= 4'h9)
		begin
			if (s.hour_format_select)
				hour_ok = s.alarm_hour_value <= rtcac_pkg::HOUR24_MAX;
			else
				hour_ok = (s.alarm_hour_value[7:6] == 2'h0)
					&& (s.alarm_hour_value[4:0] >= rtcac_pkg::HOUR12_MIN)
					&& (s.alarm_hour_value[4:0] <= rtcac_pkg::HOUR12_MAX);
		end
	end

	// compare enable, minute, hour and weekday select
	always_comb
	begin
		match_now = s.alarm_compare_enable && min_ok && hour_ok
			&& (cur_time.minute == s.alarm_minute_value)
			&& (cur_time.hour == s.alarm_hour_value)
			&& (cur_time.weekday < rtcac_pkg::WEEKDAY_COUNT)
			// day select bit gates the alarm
			&& s.alarm_weekday_mask[cur_time.weekday];
	end

	always_comb
	begin
		logic per_set;
		logic alm_set;
		per_set = s.counter_run_enable && periodic_tick;
		alm_set = match_now && !s.match_d;
		next_s = s;
		next_s.match_d = match_now;
		next_s.rdata = 8'h00;
		if (sfr_req.wr)
		begin
			// alarm registers accepted in any order
			case (sfr_req.addr)
				rtcac_pkg::ADDR_ALARM_MIN:
					next_s.alarm_minute_value = sfr_req.wdata & rtcac_pkg::MASK_ALARM_MIN;
				rtcac_pkg::ADDR_ALARM_HOUR:
				begin
					next_s.alarm_hour_value = sfr_req.wdata & rtcac_pkg::MASK_ALARM_HOUR;
					next_s.hour_written = 1'b1;
				end
				// bit7 of weekday mask stays zero
				rtcac_pkg::ADDR_ALARM_WDAY:
					next_s.alarm_weekday_mask = sfr_req.wdata & rtcac_pkg::MASK_ALARM_WDAY;
				rtcac_pkg::ADDR_CTRL:
				begin
					next_s.counter_run_enable = sfr_req.wdata[rtcac_pkg::CTRL_RUN_BIT];
					next_s.hour_format_select = sfr_req.wdata[rtcac_pkg::CTRL_FMT_BIT];
					next_s.alarm_compare_enable = sfr_req.wdata[rtcac_pkg::CTRL_ALEN_BIT];
					next_s.counter_hold_request = sfr_req.wdata[rtcac_pkg::CTRL_HREQ_BIT];
					// untouched hour follows the 24h reset encoding
					if (!s.hour_written && sfr_req.wdata[rtcac_pkg::CTRL_FMT_BIT])
						next_s.alarm_hour_value = rtcac_pkg::RST_HOUR_24;
				end
				rtcac_pkg::ADDR_STAT:
				begin
					if (!sfr_req.wdata[rtcac_pkg::STAT_PER_BIT])
						next_s.periodic_event_flag = 1'b0;
					if (!sfr_req.wdata[rtcac_pkg::STAT_ALM_BIT])
						next_s.alarm_match_flag = 1'b0;
				end
				default:
					next_s.rdata = 8'h00;
			endcase
		end
		if (sfr_req.rd)
		begin
			case (sfr_req.addr)
				rtcac_pkg::ADDR_ALARM_MIN:
					next_s.rdata = s.alarm_minute_value;
				rtcac_pkg::ADDR_ALARM_HOUR:
					next_s.rdata = s.alarm_hour_value;
				rtcac_pkg::ADDR_ALARM_WDAY:
					next_s.rdata = s.alarm_weekday_mask;
				rtcac_pkg::ADDR_CTRL:
					next_s.rdata = {3'h0, s.counter_hold_status, s.counter_hold_request,
						s.alarm_compare_enable, s.hour_format_select, s.counter_run_enable};
				rtcac_pkg::ADDR_STAT:
					next_s.rdata = {6'h00, s.alarm_match_flag, s.periodic_event_flag};
				default:
					next_s.rdata = 8'h00;
			endcase
		end
		// hold status changes only at a subclock edge
		if (fsub_tick)
			next_s.counter_hold_status = s.counter_hold_request;
		// flags set win over clears, one shared request
		if (per_set)
			next_s.periodic_event_flag = 1'b1;
		if (alm_set)
			next_s.alarm_match_flag = 1'b1;
		next_s.irq = per_set || alm_set;
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			s <= '0;
			s.alarm_minute_value <= rtcac_pkg::RST_ALARM_MIN;
			s.alarm_hour_value <= rtcac_pkg::RST_HOUR_12;
			s.alarm_weekday_mask <= rtcac_pkg::RST_ALARM_WDAY;
		end
		else
			s <= next_s;
	end

	assign sfr_rdata = s.rdata;
	assign rtc_interrupt_request = s.irq;
	assign counter_run_enable = s.counter_run_enable;
	assign hour_format_select = s.hour_format_select;
	// frozen counter may be read or written freely
	assign counter_freeze = s.counter_hold_status;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_sync_n);

	property p_wday_bit7;
		s.alarm_weekday_mask[7] == 1'b0;
	endproperty
	a_wday_bit7: assert property (p_wday_bit7) else $error("weekday mask bit7 set");

	property p_unselected_day;
		(cur_time.weekday < rtcac_pkg::WEEKDAY_COUNT && !s.alarm_weekday_mask[cur_time.weekday])
			|-> !match_now;
	endproperty
	a_unselected_day: assert property (p_unselected_day) else $error("alarm on unselected day");

	property p_noon_12h;
		(!s.hour_format_select && s.alarm_hour_value == 8'h32) |-> hour_ok;
	endproperty
	a_noon_12h: assert property (p_noon_12h) else $error("12h noon encoding rejected");

	localparam int HOUR_PM = rtcac_pkg::HOUR_PM_BIT;
	property p_pm_range;
		(!s.hour_format_select && s.alarm_hour_value[HOUR_PM] && s.alarm_hour_value[4:0] > 5'h12)
			|-> !hour_ok;
	endproperty
	a_pm_range: assert property (p_pm_range) else $error("bad afternoon hour accepted");

	property p_min_range;
		(s.alarm_minute_value[3:0] > 4'h9 || s.alarm_minute_value > 8'h59) |-> !match_now;
	endproperty
	a_min_range: assert property (p_min_range) else $error("bad minute matched");

	property p_hold_follow;
		fsub_tick |=> (counter_freeze == $past(s.counter_hold_request));
	endproperty
	a_hold_follow: assert property (p_hold_follow) else $error("hold status missed edge");

	property p_hold_still;
		!fsub_tick |=> $stable(counter_freeze);
	endproperty
	a_hold_still: assert property (p_hold_still) else $error("hold status moved off edge");

	property p_alarm_flag;
		(match_now && !s.match_d) |=> (s.alarm_match_flag && rtc_interrupt_request);
	endproperty
	a_alarm_flag: assert property (p_alarm_flag) else $error("alarm match not flagged");

	property p_periodic_irq;
		(s.counter_run_enable && periodic_tick) |=> (s.periodic_event_flag && rtc_interrupt_request);
	endproperty
	a_periodic_irq: assert property (p_periodic_irq) else $error("periodic event lost");

	property p_min_write;
		(sfr_req.wr && sfr_req.addr == rtcac_pkg::ADDR_ALARM_MIN)
			|=> (s.alarm_minute_value == ($past(sfr_req.wdata) & 8'h7f));
	endproperty
	a_min_write: assert property (p_min_write) else $error("alarm minute write lost");

	c_alarm: cover property (match_now && !s.match_d);
	c_hold: cover property (s.counter_hold_request ##[1:1000] counter_freeze);
	c_both: cover property (s.periodic_event_flag && s.alarm_match_flag);
endmodule // rtcac_alarm_ctrl
`default_nettype wire

// ===== rtcac_pkg.sv
// constants and types shared by the alarm and access-control block
`default_nettype none
package rtcac_pkg;
	// register addresses on the extended register port
	localparam logic [7:0] ADDR_ALARM_MIN = 8'h93;
	localparam logic [7:0] ADDR_ALARM_HOUR = 8'h94;
	localparam logic [7:0] ADDR_ALARM_WDAY = 8'h95;
	localparam logic [7:0] ADDR_CTRL = 8'h9c;
	localparam logic [7:0] ADDR_STAT = 8'h9d;
	// values after reset
	localparam logic [7:0] RST_ALARM_MIN = 8'h00;
	localparam logic [7:0] RST_HOUR_12 = 8'h12;
	localparam logic [7:0] RST_HOUR_24 = 8'h00;
	localparam logic [7:0] RST_ALARM_WDAY = 8'h00;
	// writable bits of each alarm register
	localparam logic [7:0] MASK_ALARM_MIN = 8'h7f;
	localparam logic [7:0] MASK_ALARM_HOUR = 8'h3f;
	localparam logic [7:0] MASK_ALARM_WDAY = 8'h7f;
	// field positions
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_FMT_BIT = 1;
	localparam int CTRL_ALEN_BIT = 2;
	localparam int CTRL_HREQ_BIT = 3;
	localparam int CTRL_HSTAT_BIT = 4;
	localparam int STAT_PER_BIT = 0;
	localparam int STAT_ALM_BIT = 1;
	localparam int HOUR_PM_BIT = 5;
	localparam logic [2:0] WEEKDAY_COUNT = 3'h7;
	// bcd limits
	localparam logic [7:0] MIN_MAX = 8'h59;
	localparam logic [7:0] HOUR24_MAX = 8'h23;
	localparam logic [4:0] HOUR12_MIN = 5'h01;
	localparam logic [4:0] HOUR12_MAX = 5'h12;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rtcac_sfr_req_t;

	typedef struct packed {
		logic [7:0] minute;
		logic [7:0] hour;
		logic [2:0] weekday;
	} rtcac_time_t;

	typedef struct packed {
		logic [7:0] alarm_minute_value;
		logic [7:0] alarm_hour_value;
		logic [7:0] alarm_weekday_mask;
		logic counter_run_enable;
		logic hour_format_select;
		logic alarm_compare_enable;
		logic counter_hold_request;
		logic counter_hold_status;
		logic hour_written;
		logic periodic_event_flag;
		logic alarm_match_flag;
		logic match_d;
		logic irq;
		logic [7:0] rdata;
	} rtcac_state_t;
endpackage
`default_nettype wire

// ===== rtcac_edge_sync.sv
// two-flop synchroniser with rising-edge pulse for the subclock pin
`default_nettype none
module rtcac_edge_sync (
	input wire logic sys_clk,
	input wire logic rst_sync_n,
	input wire logic async_in,
	output logic rise
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} rtcac_sync_t;

	rtcac_sync_t s;
	rtcac_sync_t next_s;

	always_comb
	begin
		next_s.s1 = async_in;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			s <= '0;
		else
			s <= next_s;
	end

	assign rise = s.s2 & ~s.s3;
endmodule // rtcac_edge_sync
`default_nettype wire

// ===== rtcac_alarm_ctrl_tb_top.sv
// self-checking bench for the alarm, hold handshake and interrupt block
`default_nettype none
module rtcac_alarm_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic fsub_pin = 1'b0;
	logic periodic_tick = 1'b0;
	rtcac_pkg::rtcac_sfr_req_t sfr_req = '0;
	rtcac_pkg::rtcac_time_t cur_time = '1;
	logic [7:0] sfr_rdata;
	logic rtc_interrupt_request;
	logic counter_run_enable;
	logic hour_format_select;
	logic counter_freeze;
	int num_errors = 0;
	int tests_run = 0;
	int irq_cnt = 0;
	int seed = 70029;
	int n0;

	rtcac_alarm_ctrl DUT (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.fsub_pin(fsub_pin),
		.sfr_req(sfr_req),
		.cur_time(cur_time),
		.periodic_tick(periodic_tick),
		.sfr_rdata(sfr_rdata),
		.rtc_interrupt_request(rtc_interrupt_request),
		.counter_run_enable(counter_run_enable),
		.hour_format_select(hour_format_select),
		.counter_freeze(counter_freeze)
	);

	always #20 sys_clk = ~sys_clk;
	// subclock runs free, phase unrelated to sys_clk
	always #317 fsub_pin = ~fsub_pin;
	// irq is a one-cycle pulse, so count it at every falling edge
	always @(negedge sys_clk)
		if (rtc_interrupt_request === 1'b1)
			irq_cnt++;

	task automatic end_of_test;
		if (num_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge sys_clk);
		sfr_req.wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge sys_clk);
		sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge sys_clk);
		sfr_req.rd = 1'b0;
		chk(sfr_rdata, exp);
	endtask

	function automatic bit bcd_ok(input int v, input int mx);
		return (v % 16) < 10 && v <= mx;
	endfunction

	// model of a match with the counter equal to the alarm setting
	function automatic bit hits(input int fmt, input int m, input int h, input int w, input int d);
		bit hok;
		hok = fmt ? bcd_ok(h, 'h23) : bcd_ok(h % 32, 'h12) && (h % 32) > 0;
		return bcd_ok(m, 'h59) && hok && w[d];
	endfunction

	// compare off, then alarm registers out of address order
	task automatic alarm(input int fmt, input int m, input int h, input int w, input int d,
		input int en);
		bit exp;
		m = m & 'h7f;
		h = h & 'h3f;
		w = w & 'h7f;
		exp = en && hits(fmt, m, h, w, d);
		n0 = irq_cnt;
		wr(8'h9c, 8'(1 + 2 * fmt));
		wr(8'h95, 8'(w));
		wr(8'h93, 8'(m));
		wr(8'h94, 8'(h));
		rd(8'h94, 8'(h));
		rd(8'h95, 8'(w));
		rd(8'h93, 8'(m));
		wr(8'h9c, 8'(1 + 2 * fmt + 4 * en));
		chk(8'(hour_format_select), 8'(fmt));
		@(negedge sys_clk);
		cur_time = '{minute: 8'(m), hour: 8'(h), weekday: 3'(d)};
		repeat (4) @(negedge sys_clk);
		chk(8'(irq_cnt - n0), 8'(exp));
		rd(8'h9d, 8'(2 * exp));
		wr(8'h9d, 8'h00);
		cur_time.minute = 8'hff;
	endtask

	initial
	begin
		repeat (20) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge sys_clk);
		// values after reset, unmapped address reads zero
		rd(8'h93, 8'h00);
		rd(8'h94, 8'h12);
		rd(8'h95, 8'h00);
		rd(8'h9c, 8'h00);
		rd(8'h9d, 8'h00);
		rd(8'h50, 8'h00);
		wr(8'h9c, 8'h02);
		rd(8'h94, 8'h00);
		wr(8'h95, 8'hff);
		rd(8'h95, 8'h7f);
		// periodic events count only while running
		for (int r = 0; r < 2; r++)
		begin
			wr(8'h9c, 8'(r));
			chk(8'(counter_run_enable), 8'(r));
			n0 = irq_cnt;
			periodic_tick = 1'b1;
			@(negedge sys_clk);
			periodic_tick = 1'b0;
			repeat (2) @(negedge sys_clk);
			chk(8'(irq_cnt - n0), 8'(r));
			rd(8'h9d, 8'(r));
		end
		wr(8'h9d, 8'h02);
		rd(8'h9d, 8'h00);
		// hold status follows the request at subclock ticks
		// request, poll status one, clear, poll status zero
		// each step spans far more than two subclocks, far under a second
		// periodic interrupt already seen above, so no stop wait needed
		for (int r = 1; r >= 0; r--)
		begin
			wr(8'h9c, 8'(1 + 8 * r));
			n0 = 0;
			while (counter_freeze !== r[0] && n0 < 100)
			begin
				@(negedge sys_clk);
				n0++;
			end
			chk(8'(counter_freeze), 8'(r));
			rd(8'h9c, 8'(1 + 24 * r));
		end
		alarm(0, 'h00, 'h12, 'h7f, 3, 1);
		alarm(0, 'h00, 'h32, 'h3e, 1, 1);
		alarm(1, 'h00, 'h00, 'h7f, 6, 1);
		alarm(1, 'h59, 'h12, 'h2a, 5, 1);
		alarm(0, 'h30, 'h21, 'h01, 1, 1);
		alarm(1, 'h5a, 'h10, 'h7f, 2, 1);
		alarm(0, 'h30, 'h13, 'h7f, 2, 1);
		alarm(1, 'h30, 'h24, 'h7f, 2, 1);
		alarm(1, 'h30, 'h10, 'h7f, 2, 0);
		repeat (12)
			alarm({$random(seed)} % 2, {$random(seed)} % 'h60, {$random(seed)} % 'h40,
				{$random(seed)} % 128, {$random(seed)} % 7, 1);
		end_of_test();
	end

	initial
	begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		end_of_test();
	end
endmodule // rtcac_alarm_ctrl_tb_top
`default_nettype wire
